// ==== bench/scp_props.sv ====
module scp_props #(
   parameter int BIT_CYC_P = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic h2d,
   input wire logic d2h
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned dlo;
   int unsigned dhi;
   int unsigned hlo;
   int unsigned hhi;
   logic fresh;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Ten bit times of high is longer than any high run inside one reply
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Both lines sit high through reset, so count that as long idle
         dlo <= 0;
         dhi <= 10 * BIT_CYC_P;
         hlo <= 0;
         hhi <= 10 * BIT_CYC_P;
         fresh <= 1'b1;
      end else begin
         dlo <= d2h ? 0 : dlo + 1;
         dhi <= d2h ? dhi + 1 : 0;
         hlo <= h2d ? 0 : hlo + 1;
         hhi <= h2d ? hhi + 1 : 0;
         if (d2h && dhi >= 10 * BIT_CYC_P) begin
            fresh <= 1'b1;
         end else if (d2h && dlo != 0) begin
            fresh <= 1'b0;
         end
      end
   end
   property p_rst_idle;
      $rose(presetn) |-> h2d && d2h;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("serial line not idle high after reset");
   property p_dlo_unit;
      d2h && dlo != 0 |-> dlo % BIT_CYC_P == 0;
   endproperty
   a_dlo_unit: assert property (p_dlo_unit)
      else $error("device low run not whole bit times");
   property p_dlo_max;
      dlo <= 9 * BIT_CYC_P;
   endproperty
   a_dlo_max: assert property (p_dlo_max)
      else $error("device line low too long");
   property p_dstop;
      $fell(d2h) |-> dhi >= BIT_CYC_P;
   endproperty
   a_dstop: assert property (p_dstop)
      else $error("device stop bit too short");
   property p_lead;
      d2h && dlo != 0 && fresh |-> dlo == 6 * BIT_CYC_P;
   endproperty
   a_lead: assert property (p_lead)
      else $error("reply does not open with a space");
   property p_hlo_unit;
      h2d && hlo != 0 |-> hlo % BIT_CYC_P == 0;
   endproperty
   a_hlo_unit: assert property (p_hlo_unit)
      else $error("host low run not whole bit times");
   property p_hlo_max;
      hlo <= 9 * BIT_CYC_P;
   endproperty
   a_hlo_max: assert property (p_hlo_max)
      else $error("host line low too long");
   property p_hstop;
      $fell(h2d) |-> hhi >= BIT_CYC_P;
   endproperty
   a_hstop: assert property (p_hstop)
      else $error("host stop bit too short");
endmodule

// ==== bench/sensor_uart_command_port_tb.sv ====
module sensor_uart_command_port_tb
   import scp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BC = 16;
   localparam int MC = 8000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic iface_float, nv_poll, uart_on, nv_wr, nv_poll_val;
   logic [15:0] filt_ppm, raw_ppm;
   logic [1:0] mode;
   logic [7:0] mask;
   int error_cnt = 0;
   int n_checks = 0;
   scp_if link();
   scp_dev #(.BIT_CYC_P(BC), .MEAS_CYC_P(MC)) i_scp_dev (.pclk(pclk), .presetn(presetn),
      .link(link), .iface_float(iface_float), .nv_poll(nv_poll), .filt_ppm(filt_ppm),
      .raw_ppm(raw_ppm), .uart_on(uart_on), .mode(mode), .mask(mask), .nv_wr(nv_wr),
      .nv_poll_val(nv_poll_val));
   scp_host #(.BIT_CYC_P(BC)) i_scp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   scp_props #(.BIT_CYC_P(BC)) i_scp_props (.pclk(pclk), .presetn(presetn),
      .h2d(link.h2d), .d2h(link.d2h));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Stands in for the non-volatile cell, so a reset shows what was stored
   always @(posedge pclk) begin
      if (nv_wr === 1'b1) begin
         nv_poll <= nv_poll_val;
      end
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic fail(input string msg);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask
   task automatic hang(input string msg);
      fail(msg);
      print_verdict();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) fail(what);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Read at the edge itself, before that edge's own updates land
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) hang("no pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic send_str(input string s);
      int i;
      for (int k = 0; k < s.len(); k++) begin
         for (i = 0; i < 400; i++) begin
            apb(1'b0, A_STAT, 32'h0);
            if (rd[ST_TXBUSY_BIT] === 1'b0) break;
         end
         if (i == 400) hang("transmitter stuck");
         apb(1'b1, A_TX, {24'h0, s[k]});
      end
   endtask
   task automatic expect_str(input string s, input string what);
      int i;
      logic bad;
      bad = 1'b0;
      for (int k = 0; k < s.len(); k++) begin
         for (i = 0; i < 3000; i++) begin
            apb(1'b0, A_STAT, 32'h0);
            if (rd[ST_RXVAL_BIT] === 1'b1) break;
         end
         if (i == 3000) hang({"no reply to ", what});
         apb(1'b0, A_RX, 32'h0);
         if (rd[7:0] !== s[k]) bad = 1'b1;
      end
      n_checks++;
      if (bad === 1'b1) fail({"wrong reply to ", what});
   endtask
   task automatic cmd(input string c, input string r);
      send_str(c);
      expect_str(r, c.substr(0, 0));
   endtask
   task automatic quiet(input string what);
      repeat (MC + 500) @(posedge pclk);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[ST_RXVAL_BIT], 1'b0, what);
   endtask
   task automatic do_reset;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      iface_float = 1'b1;
      nv_poll = 1'b1;
      filt_ppm = 16'h0209;
      raw_ppm = 16'h007B;
      @(posedge pclk);
      do_reset();
      chk(uart_on, 1'b1, "serial mode at power-up");
      chk(mode, MODE_POLL, "stored mode at power-up");
      chk(mask, MASK_RST, "default mask");
      iface_float <= 1'b0;
      apb(1'b0, 8'hFC, 32'h0);
      chk(err, 1'b1, "unmapped address error");
      chk(rd, 32'h0, "unmapped address data");
      cmd("K2\r\n", " ?\r\n");
      chk(uart_on, 1'b1, "select pin read only once");
      cmd("M 4\r\n", " M 00004\r\n");
      chk(mask, 8'h04, "mask set");
      cmd("K 1\r\n", " K 00001\r\n");
      chk(nv_poll_val, 1'b0, "streaming stored");
      expect_str(" Z 00521\r\n", "stream");
      filt_ppm <= 16'h0309;
      cmd("Z\r\n", " Z 00521\r\n");
      cmd("K 0\r\n", " K 00000\r\n");
      chk(mode, MODE_CMD, "command mode");
      cmd("Q\r\n", " ?\r\n");
      quiet("sleep mode sent data");
      iface_float <= 1'b1;
      do_reset();
      chk(mode, MODE_STREAM, "mode after power cycle");
      chk(mask, MASK_RST, "mask after power cycle");
      cmd("K 2\r\n", " K 00002\r\n");
      chk(nv_poll_val, 1'b1, "polling stored");
      quiet("polling mode streamed");
      cmd("Q\r\n", " Z 00777 z 00123\r\n");
      send_str("x");
      expect_str(" Z 00777 z 00123\r\n", "any character");
      send_str("\r\n");
      cmd("Q\n", " ?\r\n");
      cmd("M4\r\n", " ?\r\n");
      cmd("M 2\r\n", " M 00002\r\n");
      cmd("Q\r\n", " z 00123\r\n");
      cmd("z\r\n", " z 00123\r\n");
      print_verdict();
   end
endmodule

// ==== hw/scp_dev.sv ====
module scp_dev
   import scp_pkg::*;
#(
   parameter int BIT_CYC_P = BIT_CYC,
   parameter int MEAS_CYC_P = MEAS_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   scp_if.dev link,
   input wire logic iface_float,
   input wire logic nv_poll,
   input wire logic [15:0] filt_ppm,
   input wire logic [15:0] raw_ppm,
   output logic uart_on,
   output logic [1:0] mode,
   output logic [7:0] mask,
   output logic nv_wr,
   output logic nv_poll_val
);
   logic started;
   logic rx_busy, rx_stb;
   logic [15:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_sh, rx_byte;
   logic [2:0] ln_pos, ln_nd;
   logic [7:0] ln_cmd;
   logic ln_bad, ln_cr, ln_skip;
   logic [16:0] ln_val;
   logic [24:0] meas_cnt;
   logic [15:0] last_f, last_r;
   logic rep_pend, pend, p_nd;
   logic [7:0] p_l;
   logic [16:0] p_v;
   scp_gen_t gs;
   logic slot, g_e1, g_nd;
   logic [7:0] g_l0, g_l1;
   logic [16:0] g_v0, g_v1, rem;
   logic [3:0] dig;
   logic [2:0] didx;
   logic tx_busy, tx_q;
   logic [15:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [9:0] tx_sh;

   assign link.d2h = tx_q;

   wire [15:0] bit_last = 16'(BIT_CYC_P - 1);
   wire is_dig = rx_byte >= CH_0 && rx_byte <= CH_9;
   wire [16:0] acc = 17'(ln_val * 17'h0000A + {13'h0000, rx_byte[3:0]});
   wire end_ln = rx_stb && rx_byte == CH_LF;
   wire line_go = end_ln && !ln_skip && ln_pos != 3'h0;
   wire arg_ok = ln_cr && !ln_bad && ln_pos >= 3'h3;
   wire bare_ok = ln_cr && !ln_bad && ln_pos == 3'h1 && mode != MODE_CMD;
   wire cmd_k = ln_cmd == CH_K && arg_ok && ln_val <= 17'h00002;
   wire cmd_m = ln_cmd == CH_M && arg_ok && ln_val <= 17'h000FF;
   wire cmd_q = ln_cmd == CH_QRY && bare_ok;
   wire cmd_zf = ln_cmd == CH_ZF && bare_ok;
   wire cmd_zr = ln_cmd == CH_ZR && bare_ok;
   wire trig = rx_stb && ln_pos == 3'h0 && mode != MODE_CMD && !scp_known(rx_byte)
      && rx_byte != CH_CR && rx_byte != CH_LF;
   wire meas_tick = uart_on && mode != MODE_CMD && meas_cnt == 25'(MEAS_CYC_P - 1);
   wire take_pend = gs == GS_IDLE && pend;
   wire take_rep = gs == GS_IDLE && !pend && rep_pend;
   wire has_field = mask[MASK_FILT_BIT] || mask[MASK_RAW_BIT];
   wire [16:0] pw = scp_pow10(didx);
   wire dig_more = gs == GS_DIG && rem >= pw;
   wire send_now = !tx_busy && gs != GS_IDLE && !dig_more;
   wire [7:0] cur_l = slot ? g_l1 : g_l0;
   wire [7:0] gbyte = gs == GS_LET ? cur_l :
                      gs == GS_DIG ? CH_0 + {4'h0, dig} :
                      gs == GS_CR ? CH_CR :
                      gs == GS_LF ? CH_LF : CH_SP;

   // Receiver samples mid-bit; a false start or bad stop drops the byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_busy <= 1'b0;
         rx_cnt <= 16'h0000;
         rx_bit <= 4'h0;
         rx_sh <= 8'h00;
         rx_byte <= 8'h00;
         rx_stb <= 1'b0;
      end else begin
         rx_stb <= 1'b0;
         if (!rx_busy) begin
            if (uart_on && !link.h2d) begin
               rx_busy <= 1'b1;
               rx_cnt <= 16'(BIT_CYC_P / 2);
               rx_bit <= 4'h0;
            end
         end else if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
         end else begin
            rx_cnt <= bit_last;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && link.h2d) begin
               rx_busy <= 1'b0;
            end else if (rx_bit == 4'h9) begin
               rx_busy <= 1'b0;
               rx_stb <= link.h2d;
               rx_byte <= rx_sh;
            end else if (rx_bit != 4'h0) begin
               rx_sh <= {link.h2d, rx_sh[7:1]};
            end
         end
      end
   end

   // Line parser: letter, space, up to five digits, CR, LF
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ln_pos <= 3'h0;
         ln_nd <= 3'h0;
         ln_cmd <= 8'h00;
         ln_bad <= 1'b0;
         ln_cr <= 1'b0;
         ln_skip <= 1'b0;
         ln_val <= 17'h00000;
      end else if (rx_stb) begin
         if (rx_byte == CH_LF) begin
            ln_pos <= 3'h0;
            ln_nd <= 3'h0;
            ln_bad <= 1'b0;
            ln_cr <= 1'b0;
            ln_skip <= 1'b0;
            ln_val <= 17'h00000;
         end else if (rx_byte == CH_CR) begin
            ln_cr <= 1'b1;
         end else begin
            ln_cr <= 1'b0;
            if (ln_cr) begin
               ln_bad <= 1'b1;
            end
            if (ln_pos != 3'h7) begin
               ln_pos <= ln_pos + 3'h1;
            end
            if (ln_pos == 3'h0) begin
               ln_cmd <= rx_byte;
               ln_skip <= trig;
            end else if (ln_pos == 3'h1) begin
               if (rx_byte != CH_SP) begin
                  ln_bad <= 1'b1;
               end
            end else if (is_dig && ln_nd < 3'h5) begin
               ln_val <= acc;
               ln_nd <= ln_nd + 3'h1;
            end else begin
               ln_bad <= 1'b1;
            end
         end
      end
   end

   // Command execution; the power-up capture happens on the first edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started <= 1'b0;
         uart_on <= 1'b0;
         mode <= MODE_STREAM;
         mask <= MASK_RST;
         nv_wr <= 1'b0;
         nv_poll_val <= 1'b0;
         pend <= 1'b0;
         p_nd <= 1'b0;
         p_l <= 8'h00;
         p_v <= 17'h00000;
      end else begin
         nv_wr <= 1'b0;
         if (!started) begin
            started <= 1'b1;
            uart_on <= iface_float;
            mode <= nv_poll ? MODE_POLL : MODE_STREAM;
         end
         if (take_pend) begin
            pend <= 1'b0;
         end
         if (line_go && !cmd_q) begin
            pend <= 1'b1;
            p_nd <= 1'b0;
            if (cmd_k) begin
               mode <= ln_val[1:0];
               p_l <= CH_K;
               p_v <= ln_val;
               if (ln_val != 17'h00000) begin
                  nv_wr <= 1'b1;
                  nv_poll_val <= ln_val[1];
               end
            end else if (cmd_m) begin
               mask <= ln_val[7:0];
               p_l <= CH_M;
               p_v <= ln_val;
            end else if (cmd_zf || cmd_zr) begin
               p_l <= ln_cmd;
               p_v <= {1'b0, cmd_zf ? last_f : last_r};
            end else begin
               p_l <= CH_QMARK;
               p_nd <= 1'b1;
            end
         end
      end
   end

   // No measurement in mode 0 or with uart_on low; otherwise one result every period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_cnt <= 25'h0000000;
         last_f <= 16'h0000;
         last_r <= 16'h0000;
         rep_pend <= 1'b0;
      end else begin
         if (!uart_on || mode == MODE_CMD) begin
            meas_cnt <= 25'h0000000;
         end else if (meas_tick) begin
            meas_cnt <= 25'h0000000;
            last_f <= filt_ppm;
            last_r <= raw_ppm;
         end else begin
            meas_cnt <= meas_cnt + 25'h0000001;
         end
         if (take_rep) begin
            rep_pend <= 1'b0;
         end
         if ((meas_tick && mode == MODE_STREAM) || trig || (line_go && cmd_q)) begin
            rep_pend <= 1'b1;
         end
      end
   end

   // Response generator; decimal digits by repeated subtraction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gs <= GS_IDLE;
         slot <= 1'b0;
         g_e1 <= 1'b0;
         g_nd <= 1'b0;
         g_l0 <= 8'h00;
         g_l1 <= 8'h00;
         g_v0 <= 17'h00000;
         g_v1 <= 17'h00000;
         rem <= 17'h00000;
         dig <= 4'h0;
         didx <= 3'h0;
      end else if (take_pend) begin
         g_l0 <= p_l;
         g_v0 <= p_v;
         g_e1 <= 1'b0;
         g_nd <= p_nd;
         slot <= 1'b0;
         gs <= GS_LEAD;
      end else if (take_rep && has_field) begin
         g_l0 <= mask[MASK_FILT_BIT] ? CH_ZF : CH_ZR;
         g_v0 <= {1'b0, mask[MASK_FILT_BIT] ? last_f : last_r};
         g_l1 <= CH_ZR;
         g_v1 <= {1'b0, last_r};
         g_e1 <= mask[MASK_FILT_BIT] && mask[MASK_RAW_BIT];
         g_nd <= 1'b0;
         slot <= 1'b0;
         gs <= GS_LEAD;
      end else if (dig_more) begin
         rem <= 17'(rem - pw);
         dig <= dig + 4'h1;
      end else if (send_now) begin
         unique case (gs)
            GS_LEAD: gs <= GS_LET;
            GS_LET: gs <= g_nd ? GS_CR : GS_GAP;
            GS_GAP: begin
               gs <= GS_DIG;
               rem <= slot ? g_v1 : g_v0;
               dig <= 4'h0;
               didx <= 3'h0;
            end
            GS_DIG: begin
               dig <= 4'h0;
               didx <= didx + 3'h1;
               if (didx == LAST_DIGIT) begin
                  slot <= 1'b1;
                  gs <= (!slot && g_e1) ? GS_LEAD : GS_CR;
               end
            end
            GS_CR: gs <= GS_LF;
            GS_LF: gs <= GS_IDLE;
            default: gs <= GS_IDLE;
         endcase
      end
   end

   // Transmitter: start, eight data bits LSB first, stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_busy <= 1'b0;
         tx_q <= 1'b1;
         tx_cnt <= 16'h0000;
         tx_bit <= 4'h0;
         tx_sh <= 10'h3FF;
      end else if (!tx_busy) begin
         if (send_now) begin
            tx_busy <= 1'b1;
            tx_q <= 1'b0;
            tx_sh <= {1'b1, gbyte, 1'b0};
            tx_cnt <= bit_last;
            tx_bit <= 4'h0;
         end
      end else if (tx_cnt != 16'h0000) begin
         tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_bit == 4'h9) begin
         tx_busy <= 1'b0;
      end else begin
         tx_cnt <= bit_last;
         tx_bit <= tx_bit + 4'h1;
         tx_q <= tx_sh[1];
         tx_sh <= {1'b1, tx_sh[9:1]};
      end
   end
endmodule

// ==== hw/scp_host.sv ====
module scp_host
   import scp_pkg::*;
#(
   parameter int BIT_CYC_P = BIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   scp_if.host link
);
   logic rx_busy, rx_stb, rx_val, rx_ovr;
   logic [15:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [7:0] rx_sh, rx_data;
   logic tx_busy, tx_q;
   logic [15:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [9:0] tx_sh;

   assign link.h2d = tx_q;

   wire [15:0] bit_last = 16'(BIT_CYC_P - 1);
   wire acc_ph = psel && penable && !pready;
   wire done = psel && penable && pready;
   wire hit_tx = paddr == A_TX;
   wire hit_st = paddr == A_STAT;
   wire hit_rx = paddr == A_RX;
   wire mapped = hit_tx || hit_st || hit_rx;
   wire [31:0] stat = {29'h00000000, rx_ovr, rx_val, tx_busy};
   wire [31:0] rd_mux = pwrite ? 32'h00000000 :
                        hit_st ? stat :
                        hit_rx ? {24'h000000, rx_data} : 32'h00000000;
   wire tx_go = done && pwrite && hit_tx && !tx_busy;
   wire rx_pop = done && !pwrite && hit_rx;

   // One wait state: answer registered in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc_ph;
         if (acc_ph) begin
            prdata <= rd_mux;
            pslverr <= !mapped;
         end
      end
   end

   // Receiver; a byte landing as software pops still sets the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_busy <= 1'b0;
         rx_cnt <= 16'h0000;
         rx_bit <= 4'h0;
         rx_sh <= 8'h00;
         rx_data <= 8'h00;
         rx_stb <= 1'b0;
         rx_val <= 1'b0;
         rx_ovr <= 1'b0;
      end else begin
         rx_stb <= 1'b0;
         if (rx_pop) begin
            rx_val <= 1'b0;
            rx_ovr <= 1'b0;
         end
         if (rx_stb) begin
            rx_val <= 1'b1;
            if (rx_val && !rx_pop) begin
               rx_ovr <= 1'b1;
            end
         end
         if (!rx_busy) begin
            if (!link.d2h) begin
               rx_busy <= 1'b1;
               rx_cnt <= 16'(BIT_CYC_P / 2);
               rx_bit <= 4'h0;
            end
         end else if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
         end else begin
            rx_cnt <= bit_last;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && link.d2h) begin
               rx_busy <= 1'b0;
            end else if (rx_bit == 4'h9) begin
               rx_busy <= 1'b0;
               rx_stb <= link.d2h;
               rx_data <= rx_sh;
            end else if (rx_bit != 4'h0) begin
               rx_sh <= {link.d2h, rx_sh[7:1]};
            end
         end
      end
   end

   // Transmitter; a write while busy is dropped, software polls status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_busy <= 1'b0;
         tx_q <= 1'b1;
         tx_cnt <= 16'h0000;
         tx_bit <= 4'h0;
         tx_sh <= 10'h3FF;
      end else if (!tx_busy) begin
         if (tx_go) begin
            tx_busy <= 1'b1;
            tx_q <= 1'b0;
            tx_sh <= {1'b1, pwdata[7:0], 1'b0};
            tx_cnt <= bit_last;
            tx_bit <= 4'h0;
         end
      end else if (tx_cnt != 16'h0000) begin
         tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_bit == 4'h9) begin
         tx_busy <= 1'b0;
      end else begin
         tx_cnt <= bit_last;
         tx_bit <= tx_bit + 4'h1;
         tx_q <= tx_sh[1];
         tx_sh <= {1'b1, tx_sh[9:1]};
      end
   end
endmodule

// ==== pkg/scp_if.sv ====
interface scp_if;
   logic h2d;
   logic d2h;
   modport dev (input h2d, output d2h);
   modport host (output h2d, input d2h);
endinterface

// ==== pkg/scp_pkg.sv ====
package scp_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD = 9600;
   localparam int BIT_CYC = CLK_HZ / BAUD;
   localparam int MEAS_PERIOD_MS = 500;
   localparam int MEAS_CYC = (CLK_HZ / 1000) * MEAS_PERIOD_MS;

   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_QMARK = 8'h3F;
   localparam logic [7:0] CH_K = 8'h4B;
   localparam logic [7:0] CH_M = 8'h4D;
   localparam logic [7:0] CH_QRY = 8'h51;
   localparam logic [7:0] CH_ZF = 8'h5A;
   localparam logic [7:0] CH_ZR = 8'h7A;

   localparam logic [1:0] MODE_CMD = 2'h0;
   localparam logic [1:0] MODE_STREAM = 2'h1;
   localparam logic [1:0] MODE_POLL = 2'h2;
   localparam logic [7:0] MASK_RST = 8'h06;
   localparam int MASK_FILT_BIT = 2;
   localparam int MASK_RAW_BIT = 1;
   localparam logic [2:0] LAST_DIGIT = 3'h4;

   localparam logic [7:0] A_TX = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_RX = 8'h08;
   localparam int ST_TXBUSY_BIT = 0;
   localparam int ST_RXVAL_BIT = 1;
   localparam int ST_RXOVR_BIT = 2;

   typedef enum logic [2:0] {
      GS_IDLE = 3'b000,
      GS_LEAD = 3'b001,
      GS_LET = 3'b010,
      GS_GAP = 3'b011,
      GS_DIG = 3'b100,
      GS_CR = 3'b101,
      GS_LF = 3'b110
   } scp_gen_t;

   function automatic logic [16:0] scp_pow10(input logic [2:0] idx);
      case (idx)
         3'h0: scp_pow10 = 17'h02710;
         3'h1: scp_pow10 = 17'h003E8;
         3'h2: scp_pow10 = 17'h00064;
         3'h3: scp_pow10 = 17'h0000A;
         default: scp_pow10 = 17'h00001;
      endcase
   endfunction

   function automatic logic scp_known(input logic [7:0] c);
      scp_known = c == CH_K || c == CH_M || c == CH_QRY || c == CH_ZF || c == CH_ZR;
   endfunction
endpackage
